// ---- verilog/ddcc_top.v ----
// Digital channel control in front of three stereo DACs.
// Assumes serial inputs are already received into 24-bit words with a
// one-cycle valid pulse on ref_clk; register port is on the same clock.
//
// How it works
// RL1 - Each DAC picks its serial input
// RL2 - Oversampling bit picks 128x or 64x
// RL3 - Software picks 64x for 128/192fs clocks
// RL4 - Routing field sets left and right outputs
// RL5 - Channel zero after 1024 zero samples
// RL6 - DAC flag: both zero, powerdown, or mute
// RL7 - Flag source field drives zero flag pin
// RL8 - Enable bit turns automute on
// RL9 - Automute after 1024 zeros, quick release
// RL10 - Six 8-bit attenuations, reset 0 dB
// RL11 - Update bit applies all latches together
// RL12 - Master attenuation with same latching
// RL13 - Master write overwrites all channel values
// RL14 - FF unity, half dB steps, 00 mute
//
// Design decision made here: the plain strobed port.
module ddcc_top (
   ref_clk,
   nrst,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   in_valid,
   in_left,
   in_right,
   converter_power_down,
   channel_soft_mute,
   out_valid,
   out_left,
   out_right,
   out_mute,
   oversampling_rate_select,
   zero_flag_output,
   irq
);
`include "ddcc_defines.vh"
   input  wire        ref_clk;
   input  wire        nrst;
   input  wire [4:0]  reg_addr;
   input  wire [8:0]  reg_wdata;
   input  wire        reg_wr;
   input  wire        reg_rd;
   output reg  [8:0]  reg_rdata;
   input  wire [2:0]  in_valid;
   input  wire [71:0] in_left;
   input  wire [71:0] in_right;
   input  wire [2:0]  converter_power_down;
   input  wire [2:0]  channel_soft_mute;
   output reg  [2:0]  out_valid;
   output reg  [71:0] out_left;
   output reg  [71:0] out_right;
   output reg  [2:0]  out_mute;
   output wire        oversampling_rate_select;
   output reg         zero_flag_output;
   output wire        irq;

   // ****************************************
   // Registers
   // ****************************************
   reg  [8:0]  rxfmt_reg;
   reg  [5:0]  srcsel_reg;
   reg  [3:0]  route_reg;
   reg  [2:0]  zsel_reg;
   reg         izd_reg;
   reg  [47:0] latch_reg;
   reg  [47:0] attn_reg;
   reg  [2:0]  irq_stat_reg;
   reg  [2:0]  irq_mask_reg;
   reg  [2:0]  flag_d_reg;
   reg  [8:0]  rdata_next;

   wire        wr_attn;
   wire        wr_master;
   wire [2:0]  attn_idx;
   wire [2:0]  dac_flag;
   wire [2:0]  flag_rise;

   assign attn_idx  = reg_addr[2:0] - 3'h4;
   assign wr_attn   = reg_wr && (reg_addr >= `DDCC_ADDR_ATTN_BASE)
                      && (reg_addr <= `DDCC_ADDR_ATTN_3R);
   assign wr_master = reg_wr && (reg_addr == `DDCC_ADDR_MASTER);
   assign oversampling_rate_select = rxfmt_reg[`DDCC_OSR_BIT]; // RL2

   always @(posedge ref_clk) begin
      if (!nrst) begin
         rxfmt_reg  <= `DDCC_RXFMT_RST;
         srcsel_reg <= `DDCC_SRCSEL_RST; // RL1
         route_reg  <= `DDCC_ROUTE_RST;
         zsel_reg   <= `DDCC_ZSEL_RST;
         izd_reg    <= 1'b0;
         irq_mask_reg <= 3'h0;
      end else if (reg_wr) begin
         case (reg_addr)
            `DDCC_ADDR_RXFMT:    rxfmt_reg  <= {2'h0, reg_wdata[6:0]};
            `DDCC_ADDR_SRCSEL:   srcsel_reg <= reg_wdata[5:0];
            `DDCC_ADDR_ROUTE: begin
               route_reg <= reg_wdata[3:0];
               zsel_reg  <= reg_wdata[6:4];
               izd_reg   <= reg_wdata[`DDCC_IZD_BIT]; // RL8
            end
            `DDCC_ADDR_IRQ_MASK: irq_mask_reg <= reg_wdata[2:0];
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // Attenuation latches and applied values
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_attn
         always @(posedge ref_clk) begin
            if (!nrst) begin
               latch_reg[g*8 +: 8] <= `DDCC_ATTN_RST; // RL10
               attn_reg[g*8 +: 8]  <= `DDCC_ATTN_RST;
            end else begin
               if (wr_master) begin
                  latch_reg[g*8 +: 8] <= reg_wdata[7:0]; // RL12 RL13
               end else if (wr_attn && attn_idx == g) begin
                  latch_reg[g*8 +: 8] <= reg_wdata[7:0];
               end
               if ((wr_master || wr_attn) &&
                   reg_wdata[`DDCC_UPDATE_BIT]) begin
                  if (wr_master || attn_idx == g) begin
                     attn_reg[g*8 +: 8] <= reg_wdata[7:0]; // RL11
                  end else begin
                     attn_reg[g*8 +: 8] <= latch_reg[g*8 +: 8]; // RL11
                  end
               end
            end
         end
      end
   endgenerate

   // ****************************************
   // Datapath per DAC
   // ****************************************
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_dac
         wire [1:0]  sel;
         wire        v;
         wire [23:0] sl;
         wire [23:0] sr;
         wire [24:0] sum;
         wire [23:0] avg;
         reg  [23:0] ml;
         reg  [23:0] mr;
         wire        zl;
         wire        zr;
         wire        both_zero;
         wire [23:0] gl;
         wire [23:0] gr;

         assign sel = srcsel_reg[g*2 +: 2];
         assign v   = (sel == 2'h3) ? 1'b0 : in_valid[sel]; // RL1
         assign sl  = (sel == 2'h3) ? 24'h000000 : in_left[sel*24 +: 24];
         assign sr  = (sel == 2'h3) ? 24'h000000 : in_right[sel*24 +: 24];
         assign sum = {sl[23], sl} + {sr[23], sr};
         assign avg = sum[24:1];

         always @* begin
            case (route_reg[1:0]) // RL4
               2'h1:    ml = sl;
               2'h2:    ml = sr;
               2'h3:    ml = avg;
               default: ml = 24'h000000;
            endcase
            case (route_reg[3:2]) // RL4
               2'h1:    mr = sl;
               2'h2:    mr = sr;
               2'h3:    mr = avg;
               default: mr = 24'h000000;
            endcase
         end

         ddcc_zero_det u_zl (
            .ref_clk      (ref_clk),
            .nrst         (nrst),
            .sample_valid (v),
            .sample_zero  (sl == 24'h000000),
            .is_zero      (zl)
         );
         ddcc_zero_det u_zr (
            .ref_clk      (ref_clk),
            .nrst         (nrst),
            .sample_valid (v),
            .sample_zero  (sr == 24'h000000),
            .is_zero      (zr)
         );

         // Automute drops as soon as a non-zero sample arrives
         assign both_zero = zl && zr;
         assign dac_flag[g] = both_zero || converter_power_down[g]
                              || channel_soft_mute[g]; // RL6

         ddcc_gain u_gl (.code(attn_reg[(2*g)*8 +: 8]), .din(ml),
                         .dout(gl));
         ddcc_gain u_gr (.code(attn_reg[(2*g+1)*8 +: 8]), .din(mr),
                         .dout(gr));

         always @(posedge ref_clk) begin
            if (!nrst) begin
               out_valid[g]         <= 1'b0;
               out_left[g*24 +: 24]  <= 24'h000000;
               out_right[g*24 +: 24] <= 24'h000000;
               out_mute[g]          <= 1'b0;
            end else begin
               out_valid[g] <= v;
               out_mute[g]  <= izd_reg && both_zero; // RL9
               if (v) begin
                  out_left[g*24 +: 24]  <= gl;
                  out_right[g*24 +: 24] <= gr;
               end
            end
         end
      end
   endgenerate

   // ****************************************
   // Zero flag and interrupts
   // ****************************************
   always @(posedge ref_clk) begin
      if (!nrst) begin
         zero_flag_output <= 1'b0;
         flag_d_reg       <= 3'h0;
         irq_stat_reg     <= 3'h0;
      end else begin
         case (zsel_reg) // RL7
            3'h0:    zero_flag_output <= &dac_flag;
            3'h1:    zero_flag_output <= dac_flag[0];
            3'h2:    zero_flag_output <= dac_flag[1];
            3'h3:    zero_flag_output <= dac_flag[2];
            default: zero_flag_output <= 1'b0;
         endcase
         flag_d_reg <= dac_flag;
         // Set wins over a clearing write in the same cycle
         if (reg_wr && reg_addr == `DDCC_ADDR_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg & ~reg_wdata[2:0]) | flag_rise;
         end else begin
            irq_stat_reg <= irq_stat_reg | flag_rise;
         end
      end
   end

   assign flag_rise = dac_flag & ~flag_d_reg;
   assign irq = |(irq_stat_reg & irq_mask_reg);

   // ****************************************
   // Read port
   // ****************************************
   always @* begin
      rdata_next = 9'h000;
      case (reg_addr)
         `DDCC_ADDR_RXFMT:    rdata_next = rxfmt_reg;
         `DDCC_ADDR_SRCSEL:   rdata_next = {3'h0, srcsel_reg};
         `DDCC_ADDR_ROUTE:    rdata_next = {1'b0, izd_reg, zsel_reg,
                                            route_reg};
         `DDCC_ADDR_CTRL:     rdata_next = {6'h00, dac_flag};
         `DDCC_ADDR_ATTN_1L:  rdata_next = {1'b0, latch_reg[7:0]};
         `DDCC_ADDR_ATTN_1R:  rdata_next = {1'b0, latch_reg[15:8]};
         `DDCC_ADDR_ATTN_2L:  rdata_next = {1'b0, latch_reg[23:16]};
         `DDCC_ADDR_ATTN_2R:  rdata_next = {1'b0, latch_reg[31:24]};
         `DDCC_ADDR_ATTN_3L:  rdata_next = {1'b0, latch_reg[39:32]};
         `DDCC_ADDR_ATTN_3R:  rdata_next = {1'b0, latch_reg[47:40]};
         `DDCC_ADDR_IRQ_STAT: rdata_next = {6'h00, irq_stat_reg};
         `DDCC_ADDR_IRQ_MASK: rdata_next = {6'h00, irq_mask_reg};
         default:             rdata_next = 9'h000;
      endcase
   end

   always @(posedge ref_clk) begin
      if (!nrst) begin
         reg_rdata <= 9'h000;
      end else if (reg_rd) begin
         reg_rdata <= rdata_next;
      end else begin
         reg_rdata <= 9'h000;
      end
   end
endmodule // ddcc_top

// Half-dB-step gain: 6 dB per 12 codes as shift, fine step by table.
module ddcc_gain (
   code,
   din,
   dout
);
   input  wire [7:0]  code;
   input  wire [23:0] din;
   output reg  [23:0] dout;

   reg  [7:0]  down;
   reg  [7:0]  quot;
   reg  [7:0]  rem;
   reg  [4:0]  shift;
   reg  [3:0]  fine;
   reg  [15:0] mult;
   reg  [39:0] prod;
   reg  [23:0] shifted;

   always @* begin
      down  = 8'hFF - code;
      quot  = down / 8'h0C;
      rem   = down % 8'h0C;
      shift = quot[4:0];
      fine  = rem[3:0];
      // Fine table holds half-dB gains rounded to 16-bit fractions
      case (fine)
         4'h0: mult = 16'hFFFF;
         4'h1: mult = 16'hF1AE;
         4'h2: mult = 16'hE429;
         4'h3: mult = 16'hD766;
         4'h4: mult = 16'hCB59;
         4'h5: mult = 16'hBFF9;
         4'h6: mult = 16'hB53C;
         4'h7: mult = 16'hAB19;
         4'h8: mult = 16'hA186;
         4'h9: mult = 16'h987D;
         4'hA: mult = 16'h8FF6;
         default: mult = 16'h87E8;
      endcase
      shifted = $signed(din) >>> shift;
      // Low 40 bits of the extended product equal the signed product
      prod = {{16{shifted[23]}}, shifted} * {24'h000000, mult};
      if (code == 8'h00) begin
         dout = 24'h000000; // RL14
      end else if (code == 8'hFF) begin
         dout = din; // RL14
      end else begin
         dout = prod[39:16]; // RL14
      end
   end
endmodule // ddcc_gain

// ---- verilog/ddcc_defines.vh ----
// Constants for the DAC digital channel control block.
// Assumes a 9-bit register port with printed offsets used as addresses.
`ifndef DDCC_DEFINES_VH
`define DDCC_DEFINES_VH
// ****************************************
// Register offsets
// ****************************************
`define DDCC_ADDR_RXFMT     5'h0C
`define DDCC_ADDR_SRCSEL    5'h0F
`define DDCC_ADDR_ROUTE     5'h10
`define DDCC_ADDR_CTRL      5'h11
`define DDCC_ADDR_ATTN_BASE 5'h14
`define DDCC_ADDR_ATTN_1L   5'h14
`define DDCC_ADDR_ATTN_1R   5'h15
`define DDCC_ADDR_ATTN_2L   5'h16
`define DDCC_ADDR_ATTN_2R   5'h17
`define DDCC_ADDR_ATTN_3L   5'h18
`define DDCC_ADDR_ATTN_3R   5'h19
`define DDCC_ADDR_MASTER    5'h1C
`define DDCC_ADDR_IRQ_STAT  5'h1D
`define DDCC_ADDR_IRQ_MASK  5'h1E
// ****************************************
// Field positions
// ****************************************
`define DDCC_OSR_BIT        6
`define DDCC_IZD_BIT        7
`define DDCC_UPDATE_BIT     8
// ****************************************
// Reset values
// ****************************************
`define DDCC_RXFMT_RST      9'h00A
`define DDCC_SRCSEL_RST     6'h24
`define DDCC_ROUTE_RST      4'h9
`define DDCC_ZSEL_RST       3'h0
`define DDCC_ATTN_RST       8'hFF
// ****************************************
// Timing counts
// ****************************************
`define DDCC_ZERO_RUN       11'h400
`endif

// ---- verilog/ddcc_zero_det.v ----
// Zero detector for one channel of sample stream.
// Assumes sample_valid is a one-cycle pulse on ref_clk.
module ddcc_zero_det (
   ref_clk,
   nrst,
   sample_valid,
   sample_zero,
   is_zero
);
`include "ddcc_defines.vh"
   input  wire        ref_clk;
   input  wire        nrst;
   input  wire        sample_valid;
   input  wire        sample_zero;
   output wire        is_zero;

   reg  [10:0] run_reg;

   always @(posedge ref_clk) begin
      if (!nrst) begin
         run_reg <= 11'h000;
      end else if (sample_valid) begin
         if (!sample_zero) begin
            run_reg <= 11'h000;
         end else if (run_reg != `DDCC_ZERO_RUN) begin
            run_reg <= run_reg + 11'h001;
         end
      end
   end

   assign is_zero = (run_reg == `DDCC_ZERO_RUN); // RL5
endmodule // ddcc_zero_det

// ---- testbench/ddcc_src_model.sv ----
// Host audio source model on the three serial inputs.
// Assumes samples are wanted as one-cycle valid pulses on ref_clk.
module ddcc_src_model (
   input  wire         ref_clk,
   input  wire         run,
   input  wire         zero,
   output logic [2:0]  in_valid,
   output logic [71:0] in_left,
   output logic [71:0] in_right,
   output int          n_sent
);
   timeunit 1ns;
   timeprecision 1ns;
   int ph = 0;
   initial begin
      in_valid = 3'h0;
      in_left = 72'h0;
      in_right = 72'h0;
      n_sent = 0;
   end
   // Idle data toggles so nothing is read outside a valid pulse
   always @(posedge ref_clk) begin
      ph <= (ph + 1) % 4;
      in_valid <= 3'h0;
      in_left <= ~in_left;
      in_right <= ~in_right;
      if (run && ph == 0) begin
         in_valid <= 3'h7;
         n_sent <= n_sent + 1;
         in_left <= zero ? 72'h0 : 72'({$urandom, $urandom, $urandom});
         in_right <= zero ? 72'h0 : 72'({$urandom, $urandom, $urandom});
      end
   end
endmodule // ddcc_src_model

// ---- testbench/ddcc_monitor.sv ----
// Checker for ddcc_top: register, data path and flag timing.
// Assumes it sees only the top module's ports.
module ddcc_monitor (
   input wire        ref_clk,
   input wire        nrst,
   input wire [4:0]  reg_addr,
   input wire [8:0]  reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [8:0]  reg_rdata,
   input wire [2:0]  in_valid,
   input wire [71:0] in_left,
   input wire [71:0] in_right,
   input wire [2:0]  converter_power_down,
   input wire [2:0]  channel_soft_mute,
   input wire [2:0]  out_valid,
   input wire [2:0]  out_mute,
   input wire        oversampling_rate_select,
   input wire        zero_flag_output,
   input wire        irq
);
   timeunit 1ns;
   timeprecision 1ns;
   reg  [5:0] src_reg;
   reg  [7:0] ctl_reg;
   wire [1:0] s0  = src_reg[1:0];
   wire [2:0] zs  = ctl_reg[6:4];
   wire [2:0] hit = converter_power_down | channel_soft_mute;
   // ****
   // Register shadows
   // ****
   always @(posedge ref_clk) begin
      if (!nrst) begin
         src_reg <= 6'h24;
         ctl_reg <= 8'h09;
      end else if (reg_wr && reg_addr == 5'h0F) begin
         src_reg <= reg_wdata[5:0];
      end else if (reg_wr && reg_addr == 5'h10) begin
         ctl_reg <= reg_wdata[7:0];
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence route_wr; reg_wr && reg_addr == 5'h10; endsequence
   sequence route_rd; reg_rd && reg_addr == 5'h10; endsequence
   a_route_readback: assert property (
      route_wr ##1 route_rd |=> reg_rdata[7:0] == $past(reg_wdata[7:0], 2))
      else $error("routing register read back wrong");
   a_osr_follow: assert property (
      reg_wr && reg_addr == 5'h0C |=>
      oversampling_rate_select == $past(reg_wdata[6]))
      else $error("oversampling bit not applied");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 9'h000)
      else $error("read data outside read cycle");
   a_src_valid: assert property (
      in_valid[s0] && s0 != 2'd3 |=> out_valid[0])
      else $error("selected input did not reach first converter");
   a_mute_release: assert property (
      in_valid[s0] && s0 != 2'd3 && (in_left[s0*24 +: 24] != 24'h0 ||
      in_right[s0*24 +: 24] != 24'h0) |-> ##[1:2] !out_mute[0])
      else $error("automute kept after non-zero sample");
   a_mute_off: assert property (
      $past(nrst && !ctl_reg[7]) |-> out_mute == 3'h0)
      else $error("automute while disabled");
   a_flag_all: assert property (
      $past(nrst && zs == 3'h0 && hit == 3'h7) |-> zero_flag_output)
      else $error("combined zero flag low");
   a_flag_dac: assert property (
      $past(nrst && !zs[2] && zs != 3'h0 && hit[zs[1:0] - 2'd1])
      |-> zero_flag_output)
      else $error("converter zero flag low");
   a_flag_off: assert property (
      $past(nrst && zs[2]) |-> !zero_flag_output)
      else $error("zero flag high with constant source");
   a_irq_masked: assert property (
      reg_wr && reg_addr == 5'h1E && reg_wdata[2:0] == 3'h0 |=> !irq)
      else $error("interrupt high with all masked");
endmodule // ddcc_monitor
bind ddcc_top ddcc_monitor u_ddcc_monitor (.*);

// ---- testbench/tb_top.sv ----
// Self-checking bench for ddcc_top with a data path scoreboard.
// Assumes the source model and checker are compiled before it.
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0;
   logic        run = 0, zero = 0, osr, zf, irq;
   logic [4:0]  reg_addr = 0;
   logic [8:0]  reg_wdata = 0;
   wire  [8:0]  reg_rdata;
   logic [2:0]  pd = 0, sm = 0, in_valid, out_valid, out_mute;
   logic [71:0] in_left, in_right, out_left, out_right;
   logic [5:0]  src = 6'h24;
   logic [3:0]  pl = 4'h9;
   logic [47:0] q[3][$];
   int          n_errors = 0, checks = 0, n_sent;
   int          att[6] = '{default: 255}, lat[6] = '{default: 255};
   ddcc_top u_ddcc_top (.ref_clk(ref_clk), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
      .in_left(in_left), .in_right(in_right), .converter_power_down(pd),
      .channel_soft_mute(sm), .out_valid(out_valid), .out_left(out_left),
      .out_right(out_right), .out_mute(out_mute), .irq(irq),
      .oversampling_rate_select(osr), .zero_flag_output(zf));
   ddcc_src_model u_ddcc_src_model (.ref_clk(ref_clk), .run(run),
      .zero(zero), .in_valid(in_valid), .in_left(in_left),
      .in_right(in_right), .n_sent(n_sent));
   initial forever #20 ref_clk = ~ref_clk;
   // ****
   // Shared tasks
   // ****
   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [8:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1;
      @(posedge ref_clk);
      reg_wr <= 0;
      if (a >= 5'h14 && a <= 5'h19) lat[a - 5'h14] = d[7:0];
      if (a == 5'h1C) foreach (lat[i]) lat[i] = d[7:0];
      if (d[8] && a inside {[5'h14:5'h19], 5'h1C}) att = lat;
      if (a == 5'h0F) src = d[5:0];
      if (a == 5'h10) pl = d[3:0];
   endtask
   task automatic rd(input logic [4:0] a, input logic [8:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1;
      @(posedge ref_clk);
      reg_rd <= 0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic burst(input int n, input logic z);
      int t;
      @(posedge ref_clk);
      t = n_sent + n;
      zero <= z;
      run <= 1;
      while (n_sent < t) @(posedge ref_clk);
      run <= 0;
      repeat (4) @(posedge ref_clk);
   endtask
   function automatic logic [23:0] mix(logic [1:0] m, logic [23:0] l,
      logic [23:0] r, int a);
      logic [24:0] s;
      s = {l[23], l} + {r[23], r};
      if (a == 0 || m == 0) return 24'h0;
      return m == 1 ? l : m == 2 ? r : s[24:1];
   endfunction
   // ****
   // Scoreboard
   // ****
   always @(posedge ref_clk) begin
      for (int k = 0; k < 3; k++) begin
         int s;
         logic [23:0] l, r;
         logic [47:0] e;
         s = src[2*k +: 2];
         if (out_valid[k] === 1'b1) begin
            e = q[k].size() ? q[k].pop_front() : 'x;
            chk({out_left[k*24 +: 24], out_right[k*24 +: 24]}, e);
         end
         if (nrst && s < 3 && in_valid[s]) begin
            l = in_left[s*24 +: 24];
            r = in_right[s*24 +: 24];
            q[k].push_back({mix(pl[1:0], l, r, att[2*k]),
               mix(pl[3:2], l, r, att[2*k+1])});
         end
      end
   end
   initial begin
      #2000000;
      n_errors++;
      complete_run;
   end
   initial begin
      void'($urandom(42728));
      repeat (12) @(posedge ref_clk);
      nrst <= 1;
      rd(5'h0F, 9'h024);
      rd(5'h10, 9'h009);
      rd(5'h0C, 9'h00A);
      for (int a = 20; a <= 28; a++)
         rd(5'(a), a inside {26, 27, 28} ? 9'h000 : 9'h0FF);
      wr(5'h0F, 9'h006);
      for (int m = 0; m < 16; m++) begin
         wr(5'h10, 9'(m));
         burst(3, 0);
      end
      wr(5'h10, 9'h009);
      wr(5'h14, 9'h000);
      burst(2, 0);
      wr(5'h15, 9'h1FF);
      burst(2, 0);
      wr(5'h1C, 9'h000);
      rd(5'h17, 9'h000);
      wr(5'h17, 9'h1FF);
      burst(2, 0);
      wr(5'h1C, 9'h1FF);
      burst(2, 0);
      wr(5'h0C, 9'h04A); // 64x for a 128fs clock
      #1 chk(osr, 1);
      wr(5'h1E, 9'h007);
      burst(1023, 1);
      #1 chk({zf, out_mute}, 4'h0);
      burst(1, 1);
      #1 chk({zf, out_mute, irq}, 5'h11);
      rd(5'h11, 9'h007);
      rd(5'h1D, 9'h007);
      wr(5'h10, 9'h089);
      @(posedge ref_clk) #1 chk(out_mute, 3'h7);
      wr(5'h1E, 9'h000);
      wr(5'h1D, 9'h007);
      wr(5'h1E, 9'h007);
      #1 chk(irq, 0);
      burst(1, 0);
      #1 chk(out_mute, 3'h0);
      @(posedge ref_clk) pd <= 3'h2;
      wr(5'h10, 9'h029);
      @(posedge ref_clk) #1 chk(zf, 1);
      @(posedge ref_clk) sm <= 3'h4;
      wr(5'h10, 9'h039);
      @(posedge ref_clk) #1 chk(zf, 1);
      @(posedge ref_clk) sm <= 3'h5;
      wr(5'h10, 9'h009);
      @(posedge ref_clk) #1 chk(zf, 1);
      // Write then read with no gap between the strobes
      @(posedge ref_clk);
      reg_addr <= 5'h10;
      reg_wdata <= 9'h0B6;
      reg_wr <= 1;
      @(posedge ref_clk);
      reg_wr <= 0;
      reg_rd <= 1;
      @(posedge ref_clk);
      reg_rd <= 0;
      #1 chk(reg_rdata, 9'h0B6);
      wr(5'h10, 9'h049);
      @(posedge ref_clk) #1 chk(zf, 0);
      complete_run;
   end
endmodule // tb_top
